// *** core/safety_gate_regs.svh ***
`ifndef SAFETY_GATE_REGS_SVH
`define SAFETY_GATE_REGS_SVH
// register word addresses
`define SG_ADDR_CFG     4'h0
`define SG_ADDR_DISC1   4'h1
`define SG_ADDR_DISC2   4'h2
`define SG_ADDR_SYNC    4'h3
`define SG_ADDR_STATUS  4'h4
// configuration field positions
`define SG_CFG_TYPE_LSB 0
`define SG_CFG_TYPE_MSB 2
`define SG_CFG_FTEST    3
`define SG_CFG_FAULT    4
// timer settings, counted in 10 ms steps
`define SG_STEP_MS      10
`define SG_DISC_RST     12'h003
`define SG_SYNC_RST     12'h01e
`define SG_TIME_MAX     12'hbb8
// clock and scan step derivation
`define SG_CLK_HZ       25000000
`define SG_STEP_CYCLES  (`SG_CLK_HZ / 1000 * `SG_STEP_MS)
`endif

// *** core/safety_gate_pkg.sv ***
package safety_gate_pkg;
  typedef enum logic [2:0] {
    IN_SINGLE, IN_EQUIV1, IN_COMP1, IN_EQUIV2, IN_COMP2
  } inType_t;
  typedef enum logic [1:0] {
    GT_CLOSE1, GT_OPEN, GT_CLOSE2, GT_DONE
  } gateTest_t;
  typedef struct packed {
    logic disc1;
    logic disc2;
    logic sync;
    logic ftest;
  } err_t;
  typedef struct packed {
    inType_t   inType;
    logic      ftestEn;
    logic      useFault;
    logic [11:0] disc1;
    logic [11:0] disc2;
    logic [11:0] syncT;
  } cfg_t;
  typedef struct packed {
    logic [23:0] div;
    cfg_t        cfg;
    logic [11:0] dCnt1;
    logic [11:0] dCnt2;
    logic [11:0] sCnt;
    logic        sArm;
    logic        runPrev;
    logic        treqPrev;
    err_t        err;
    logic        armReset;
    logic        testRequired;
    gateTest_t [1:0] gt;
    logic        enable;
    logic [15:0] rdata;
  } state_t;
endpackage

// *** core/safety_gate_monitor.sv ***
`timescale 1ns/1ns
`include "safety_gate_regs.svh"
// Summary of operation
// - single follows input one; pair needs both
// - complementary pair: NC on, NO off
// - two equivalent pairs need all four on
// - two complementary pairs: one, three on only
// - any error drops enable, raises fault, flags
// - fault output only when configured in use
// - errors reported independently; sync still checked
// - no test: clear on inactive then active
// - IDLE to RUN clears all errors
// - test pending: clear by active, inactive, active
// - two-pair discrepancy clears after both cycle
// - completed gate test gates enable when enabled
// - test required on entering RUN
// - second test request before completion is error
// - any error demands a new gate test
// - test-required output holds until test done
// - request beats completion in same cycle
// - test is closed, open, closed per pair
// - each pair completes test independently
// - discrepancy time 0..30 s, zero disables
// - sync time 0..30 s, zero disables
// - start of operation clears errors and timers
module safety_gate_monitor
  import safety_gate_pkg::*;
#(
  parameter int STEP_CYCLES = `SG_STEP_CYCLES
) (
  input  wire logic        sys_clk,       // 25 MHz clock
  input  wire logic        reset,         // sync reset, high
  input  wire logic [3:0]  gateIn,        // contact inputs 1..4
  input  wire logic        testRequest,   // machine test request
  input  wire logic        runMode,       // controller in RUN
  input  wire logic [3:0]  regAddr,       // register address
  input  wire logic [15:0] regWdata,      // register write data
  input  wire logic        regWr,         // write strobe
  input  wire logic        regRd,         // read strobe
  output logic      [15:0] regRdata,      // read data, next cycle
  output logic             outputEnable,  // gate closed and healthy
  output logic             faultPresent,  // any error, if used
  output logic             discErr1,      // pair 1 discrepancy
  output logic             discErr2,      // pair 2 discrepancy
  output logic             syncErr,       // pair synchronization
  output logic             testErr,       // function test error
  output logic             testRequired   // gate test pending
);

  // ==========================================================
  // helpers
  function automatic logic twoPairs(input inType_t t);
    return (t == IN_EQUIV2) || (t == IN_COMP2);
  endfunction

  function automatic logic isComp(input inType_t t);
    return (t == IN_COMP1) || (t == IN_COMP2);
  endfunction

  localparam logic [23:0] STEP_LAST = 24'(STEP_CYCLES - 1);

  state_t st_ff;
  state_t nxt_st;

  logic       tick;
  logic [1:0] act;
  logic [1:0] inact;
  logic [1:0] mism;
  logic       allAct;
  logic       allInact;
  logic       runRise;
  logic       treqRise;
  logic       discHit1;
  logic       discHit2;
  logic       syncHit;
  logic       anyErr;
  logic       testDone;
  err_t       newErr;

  // ==========================================================
  // input evaluation
  always_comb begin
    tick = (st_ff.div == STEP_LAST);
    if (st_ff.cfg.inType == IN_SINGLE) begin
      act[0]   = gateIn[0];
      inact[0] = !gateIn[0];
    end else if (isComp(st_ff.cfg.inType)) begin
      act[0]   = gateIn[0] && !gateIn[1];
      inact[0] = !gateIn[0] && gateIn[1];
    end else begin
      act[0]   = gateIn[0] && gateIn[1];
      inact[0] = !gateIn[0] && !gateIn[1];
    end
    if (!twoPairs(st_ff.cfg.inType)) begin
      act[1]   = 1'b1;
      inact[1] = 1'b1;
    end else if (isComp(st_ff.cfg.inType)) begin
      act[1]   = gateIn[2] && !gateIn[3];
      inact[1] = !gateIn[2] && gateIn[3];
    end else begin
      act[1]   = gateIn[2] && gateIn[3];
      inact[1] = !gateIn[2] && !gateIn[3];
    end
    mism     = ~act & ~inact;
    allAct   = &act;
    allInact = inact[0] && (inact[1] || !twoPairs(st_ff.cfg.inType));
    runRise  = runMode && !st_ff.runPrev;
    treqRise = testRequest && !st_ff.treqPrev;
    // zero setting disables each check
    discHit1 = mism[0] && (st_ff.cfg.disc1 != 12'h000)
               && (st_ff.dCnt1 >= st_ff.cfg.disc1);
    discHit2 = mism[1] && (st_ff.cfg.disc2 != 12'h000)
               && (st_ff.dCnt2 >= st_ff.cfg.disc2);
    syncHit  = st_ff.sArm && (act[0] != act[1])
               && (st_ff.cfg.syncT != 12'h000)
               && (st_ff.sCnt >= st_ff.cfg.syncT);
    anyErr   = |st_ff.err;
    testDone = st_ff.testRequired && (st_ff.gt[0] == GT_DONE)
               && (st_ff.gt[1] == GT_DONE);
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    newErr = '0;
    nxt_st.div = tick ? 24'h000000 : st_ff.div + 24'h000001;

    if (regWr) begin
      unique case (regAddr)
        `SG_ADDR_CFG: begin
          nxt_st.cfg.inType   =
            inType_t'(regWdata[`SG_CFG_TYPE_MSB:`SG_CFG_TYPE_LSB]);
          nxt_st.cfg.ftestEn  = regWdata[`SG_CFG_FTEST];
          nxt_st.cfg.useFault = regWdata[`SG_CFG_FAULT];
        end
        `SG_ADDR_DISC1: nxt_st.cfg.disc1 = regWdata[11:0];
        `SG_ADDR_DISC2: nxt_st.cfg.disc2 = regWdata[11:0];
        `SG_ADDR_SYNC:  nxt_st.cfg.syncT = regWdata[11:0];
        default: ;
      endcase
    end

    nxt_st.rdata = 16'h0000;
    if (regRd) begin
      unique case (regAddr)
        `SG_ADDR_CFG: nxt_st.rdata = {11'h000, st_ff.cfg.useFault,
                                      st_ff.cfg.ftestEn,
                                      st_ff.cfg.inType};
        `SG_ADDR_DISC1:  nxt_st.rdata = {4'h0, st_ff.cfg.disc1};
        `SG_ADDR_DISC2:  nxt_st.rdata = {4'h0, st_ff.cfg.disc2};
        `SG_ADDR_SYNC:   nxt_st.rdata = {4'h0, st_ff.cfg.syncT};
        `SG_ADDR_STATUS: nxt_st.rdata = {9'h000, st_ff.testRequired,
                                         st_ff.err, faultPresent,
                                         st_ff.enable};
        default: nxt_st.rdata = 16'h0000;
      endcase
    end

    if (tick) begin
      nxt_st.runPrev  = runMode;
      nxt_st.treqPrev = testRequest;
      // mismatch timers, saturating
      nxt_st.dCnt1 = !mism[0] ? 12'h000 :
        (st_ff.dCnt1 == `SG_TIME_MAX) ? st_ff.dCnt1
                                      : st_ff.dCnt1 + 12'h001;
      nxt_st.dCnt2 = !mism[1] ? 12'h000 :
        (st_ff.dCnt2 == `SG_TIME_MAX) ? st_ff.dCnt2
                                      : st_ff.dCnt2 + 12'h001;
      // sync window opens from both inactive, closes on both active
      if (!twoPairs(st_ff.cfg.inType) || allAct) begin
        nxt_st.sArm = 1'b0;
      end else if (allInact) begin
        nxt_st.sArm = 1'b1;
      end
      nxt_st.sCnt = (st_ff.sArm && (act[0] != act[1])
                     && st_ff.sCnt != `SG_TIME_MAX)
                    ? st_ff.sCnt + 12'h001
                    : (st_ff.sArm && (act[0] != act[1]))
                      ? st_ff.sCnt : 12'h000;

      // each error found on its own
      newErr.disc1 = discHit1;
      newErr.disc2 = discHit2;
      newErr.sync  = syncHit;
      newErr.ftest = st_ff.cfg.ftestEn && treqRise
                     && st_ff.testRequired;

      // gate test sequencer per pair
      for (int p = 0; p < 2; p++) begin
        unique case (st_ff.gt[p])
          GT_CLOSE1: if (act[p])   nxt_st.gt[p] = GT_OPEN;
          GT_OPEN:   if (inact[p]) nxt_st.gt[p] = GT_CLOSE2;
          GT_CLOSE2: if (act[p])   nxt_st.gt[p] = GT_DONE;
          GT_DONE:   ;
        endcase
      end

      // error reset paths
      if (allInact && anyErr) begin
        nxt_st.armReset = 1'b1;
      end
      if (st_ff.cfg.ftestEn && st_ff.testRequired) begin
        if (testDone && !treqRise) begin
          nxt_st.err = '0;
        end
      end else if (st_ff.armReset && allAct && !(|mism)) begin
        nxt_st.err = '0;
      end
      if (!(|nxt_st.err)) begin
        nxt_st.armReset = 1'b0;
      end

      // test demand and completion
      if (st_ff.cfg.ftestEn) begin
        if (treqRise || (|newErr)) begin
          nxt_st.testRequired = 1'b1;
          nxt_st.gt[0] = GT_CLOSE1;
          nxt_st.gt[1] = GT_CLOSE1;
        end else if (testDone) begin
          nxt_st.testRequired = 1'b0;
        end
      end else begin
        nxt_st.testRequired = 1'b0;
      end
      if (!twoPairs(st_ff.cfg.inType)) begin
        nxt_st.gt[1] = GT_DONE;
      end
      nxt_st.err = nxt_st.err | newErr;

      // start of operation
      if (runRise) begin
        nxt_st.err          = '0;
        nxt_st.armReset     = 1'b0;
        nxt_st.dCnt1        = 12'h000;
        nxt_st.dCnt2        = 12'h000;
        nxt_st.sCnt         = 12'h000;
        nxt_st.sArm         = 1'b0;
        nxt_st.testRequired = st_ff.cfg.ftestEn;
        nxt_st.gt[0] = GT_CLOSE1;
        nxt_st.gt[1] = twoPairs(st_ff.cfg.inType) ? GT_CLOSE1 : GT_DONE;
      end

      nxt_st.enable = runMode && allAct && !(|nxt_st.err)
                      && !(st_ff.cfg.ftestEn
                           && nxt_st.testRequired);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.cfg.inType <= IN_EQUIV1;
      st_ff.cfg.disc1  <= `SG_DISC_RST;
      st_ff.cfg.disc2  <= `SG_DISC_RST;
      st_ff.cfg.syncT  <= `SG_SYNC_RST;
      st_ff.gt[0]      <= GT_CLOSE1;
      st_ff.gt[1]      <= GT_DONE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs
  assign regRdata     = st_ff.rdata;
  assign outputEnable = st_ff.enable;
  assign faultPresent = st_ff.cfg.useFault && anyErr;
  assign discErr1     = st_ff.err.disc1;
  assign discErr2     = st_ff.err.disc2;
  assign syncErr      = st_ff.err.sync;
  assign testErr      = st_ff.err.ftest;
  assign testRequired = st_ff.testRequired;

  // ==========================================================
  // checks
  property p_single;
    @(posedge sys_clk) disable iff (reset)
    tick && st_ff.cfg.inType == IN_SINGLE && !regWr
    |=> !outputEnable || $past(gateIn[0]);
  endproperty
  a_single: assert property (p_single)
    else $error("single channel enable without input one");

  property p_comp1;
    @(posedge sys_clk) disable iff (reset)
    tick && st_ff.cfg.inType == IN_COMP1 && !regWr
    |=> !outputEnable || $past(gateIn[1:0] == 2'h1);
  endproperty
  a_comp1: assert property (p_comp1)
    else $error("complementary pair enable on wrong pattern");

  property p_equiv2;
    @(posedge sys_clk) disable iff (reset)
    tick && st_ff.cfg.inType == IN_EQUIV2 && !regWr
    |=> !outputEnable || $past(gateIn == 4'hf);
  endproperty
  a_equiv2: assert property (p_equiv2)
    else $error("two equivalent pairs enable with input off");

  property p_comp2;
    @(posedge sys_clk) disable iff (reset)
    tick && st_ff.cfg.inType == IN_COMP2 && !regWr
    |=> !outputEnable || $past(gateIn == 4'h5);
  endproperty
  a_comp2: assert property (p_comp2)
    else $error("two complementary pairs enable on wrong pattern");

  property p_errOff;
    @(posedge sys_clk) disable iff (reset)
    (discErr1 || discErr2 || syncErr || testErr)
    |-> !outputEnable && (faultPresent == st_ff.cfg.useFault);
  endproperty
  a_errOff: assert property (p_errOff)
    else $error("error present while enable on or fault wrong");

  property p_faultUse;
    @(posedge sys_clk) disable iff (reset)
    !st_ff.cfg.useFault |-> !faultPresent;
  endproperty
  a_faultUse: assert property (p_faultUse)
    else $error("fault output active while unused");

  property p_runClear;
    @(posedge sys_clk) disable iff (reset)
    tick && runMode && !st_ff.runPrev
    |=> !discErr1 && !discErr2 && !syncErr && !testErr;
  endproperty
  a_runClear: assert property (p_runClear)
    else $error("errors survive start of operation");

  property p_secondReq;
    @(posedge sys_clk) disable iff (reset)
    tick && st_ff.cfg.ftestEn && testRequired && !runRise
    && testRequest && !st_ff.treqPrev
    |=> testErr && !outputEnable;
  endproperty
  a_secondReq: assert property (p_secondReq)
    else $error("second test request did not raise error");

  property p_testGate;
    @(posedge sys_clk) disable iff (reset)
    st_ff.cfg.ftestEn && outputEnable |-> !testRequired;
  endproperty
  a_testGate: assert property (p_testGate)
    else $error("enable on while gate test pending");

endmodule

// *** sim/gate_contacts_model.sv ***
`timescale 1ns/1ns
module gate_contacts_model (
  input  wire logic       sys_clk,     // bench clock
  input  wire logic [2:0] inType,      // input type in use
  input  wire logic [1:0] closed,      // gate closed, per pair
  input  wire logic [1:0] stuck,       // second contact stuck at its gate-closed level
  input  wire logic       rawEn,       // drive raw contact pattern
  input  wire logic [3:0] raw,         // raw contact pattern
  input  wire logic       reqCmd,      // machine asks for a test
  output logic      [3:0] gateIn,      // contacts 1..4
  output logic            testRequest  // machine test request
);
  logic comp;

  // complementary types: second contact of a pair opens when closed
  assign comp = (inType == 3'h2) || (inType == 3'h4);

  always @(posedge sys_clk) begin
    if (rawEn) begin
      gateIn <= raw;
    end else begin
      gateIn[0] <= closed[0];
      gateIn[1] <= stuck[0] ? ~comp : closed[0] ^ comp;
      gateIn[2] <= closed[1];
      gateIn[3] <= stuck[1] ? ~comp : closed[1] ^ comp;
    end
    testRequest <= reqCmd;
  end
endmodule

// *** sim/safety_gate_monitor_tb.sv ***
`timescale 1ns/1ns
module safety_gate_monitor_tb;
  localparam int STEP = 10;
  localparam logic [6:0] EN = 7'h01, FLT = 7'h02, TE = 7'h04;
  localparam logic [6:0] SY = 7'h08, D2 = 7'h10, D1 = 7'h20, TR = 7'h40;
  logic sys_clk = 1'b0, reset = 1'b1, runMode = 1'b1;
  logic [3:0] regAddr = 4'h0, raw = 4'h0, gateIn;
  logic [15:0] regWdata = 16'h0, regRdata;
  logic regWr = 1'b0, regRd = 1'b0, rdPend = 1'b0, chkReq = 1'b0;
  logic [2:0] inType = 3'h1;
  logic [1:0] closed = 2'h0, stuck = 2'h0;
  logic rawEn = 1'b0, reqCmd = 1'b0, testRequest;
  logic outputEnable, faultPresent, discErr1, discErr2;
  logic syncErr, testErr, testRequired;
  logic [6:0] obs;
  logic [31:0] seed = 32'hfcdf3229;
  logic [15:0] rdQ[$];
  logic [6:0] outQ[$];
  int errorCnt = 0, comparisons = 0;

  // observed outputs, laid out like the status word
  assign obs = {testRequired, discErr1, discErr2, syncErr, testErr,
                faultPresent, outputEnable};

  always #20 sys_clk = ~sys_clk;

  safety_gate_monitor #(.STEP_CYCLES(STEP)) u_dut (
    .sys_clk(sys_clk), .reset(reset), .gateIn(gateIn),
    .testRequest(testRequest), .runMode(runMode), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .outputEnable(outputEnable),
    .faultPresent(faultPresent), .discErr1(discErr1),
    .discErr2(discErr2), .syncErr(syncErr), .testErr(testErr),
    .testRequired(testRequired));

  gate_contacts_model u_model (
    .sys_clk(sys_clk), .inType(inType), .closed(closed), .stuck(stuck),
    .rawEn(rawEn), .raw(raw), .reqCmd(reqCmd), .gateIn(gateIn),
    .testRequest(testRequest));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic enFor(input int t, input logic [3:0] g);
    case (t)
      0: return g[0];
      1: return g[0] & g[1];
      2: return g[0] & ~g[1];
      3: return &g;
      default: return g == 4'h5;
    endcase
  endfunction

  task automatic cmpRd(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      errorCnt++;
      $display("[ERR] regRdata expected %h seen %h", e, g);
    end
  endtask

  task automatic cmpOut(input logic [6:0] e, input logic [6:0] g);
    comparisons++;
    if (g !== e) begin
      errorCnt++;
      $display("[ERR] outputs expected %h seen %h", e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    rdQ.push_back(e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n * STEP) @(posedge sys_clk);
  endtask

  task automatic expOut(input logic [6:0] e);
    outQ.push_back(e);
    @(posedge sys_clk);
    chkReq <= 1'b1;
    @(posedge sys_clk);
    chkReq <= 1'b0;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // result watcher: takes the oldest note whenever a result stands
  always @(posedge sys_clk) begin
    rdPend <= regRd;
    if (rdPend)
      cmpRd(rdQ.pop_front(), regRdata);
    if (chkReq)
      cmpOut(outQ.pop_front(), obs);
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    errorCnt++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    rd(4'h0, 16'h0001);
    rd(4'h1, 16'h0003);
    rd(4'h3, 16'h001e);
    rd(4'h4, 16'h0000);
    wr(4'h4, 16'hffff);
    rd(4'h4, 16'h0000);
    wr(4'h9, 16'h1234);
    rd(4'h9, 16'h0000);
    $display("test registers done");
    // checks off so only the input evaluation decides
    wr(4'h1, 16'h0);
    wr(4'h2, 16'h0);
    wr(4'h3, 16'h0);
    rawEn <= 1'b1;
    for (int t = 0; t < 5; t++) begin
      wr(4'h0, 16'(t));
      inType <= 3'(t);
      for (int i = 0; i < 20; i++) begin
        seed = lfsr(seed);
        raw <= seed[3:0];
        ticks(2);
        expOut({6'h0, enFor(t, seed[3:0])});
      end
    end
    $display("test truth tables done");
    rawEn <= 1'b0;
    wr(4'h0, 16'h0001);
    inType <= 3'h1;
    wr(4'h1, 16'h0003);
    closed <= 2'h3;
    ticks(2);
    expOut(EN);
    stuck <= 2'h1;
    closed <= 2'h0;
    ticks(5);
    expOut(D1);
    stuck <= 2'h0;
    ticks(2);
    expOut(D1);
    closed <= 2'h3;
    ticks(2);
    expOut(EN);
    stuck <= 2'h1;
    closed <= 2'h0;
    ticks(5);
    stuck <= 2'h0;
    closed <= 2'h3;
    runMode <= 1'b0;
    ticks(2);
    runMode <= 1'b1;
    ticks(2);
    expOut(EN);
    $display("test single pair errors done");
    wr(4'h0, 16'h0003);
    inType <= 3'h3;
    wr(4'h2, 16'h0003);
    ticks(2);
    expOut(EN);
    stuck <= 2'h1;
    closed <= 2'h2;
    ticks(5);
    expOut(D1);
    stuck <= 2'h0;
    ticks(2);
    closed <= 2'h3;
    ticks(2);
    expOut(D1);
    closed <= 2'h0;
    ticks(2);
    closed <= 2'h3;
    ticks(2);
    expOut(EN);
    stuck <= 2'h3;
    closed <= 2'h0;
    ticks(5);
    expOut(D1 | D2);
    stuck <= 2'h0;
    ticks(2);
    closed <= 2'h3;
    ticks(2);
    expOut(EN);
    wr(4'h3, 16'h0003);
    closed <= 2'h0;
    ticks(2);
    closed <= 2'h1;
    ticks(5);
    expOut(SY);
    closed <= 2'h0;
    ticks(2);
    closed <= 2'h3;
    ticks(2);
    expOut(EN);
    $display("test two pair errors done");
    wr(4'h0, 16'h0019);
    inType <= 3'h1;
    runMode <= 1'b0;
    ticks(2);
    runMode <= 1'b1;
    ticks(2);
    expOut(TR);
    closed <= 2'h0;
    ticks(2);
    expOut(TR);
    closed <= 2'h3;
    ticks(2);
    expOut(EN);
    reqCmd <= 1'b1;
    ticks(2);
    expOut(TR);
    reqCmd <= 1'b0;
    ticks(2);
    reqCmd <= 1'b1;
    ticks(2);
    expOut(TR | TE | FLT);
    rd(4'h4, 16'h0046);
    reqCmd <= 1'b0;
    closed <= 2'h0;
    ticks(2);
    closed <= 2'h3;
    ticks(2);
    expOut(EN);
    stuck <= 2'h1;
    closed <= 2'h0;
    ticks(5);
    stuck <= 2'h0;
    ticks(2);
    closed <= 2'h3;
    ticks(2);
    expOut(TR | D1 | FLT);
    closed <= 2'h0;
    ticks(2);
    closed <= 2'h3;
    ticks(2);
    expOut(EN);
    // two pairs: each pair runs its own gate test sequence
    wr(4'h0, 16'h001b);
    inType <= 3'h3;
    reqCmd <= 1'b1;
    ticks(2);
    expOut(TR);
    closed <= 2'h1;
    ticks(2);
    closed <= 2'h3;
    ticks(2);
    expOut(TR);
    closed <= 2'h2;
    ticks(2);
    closed <= 2'h3;
    ticks(2);
    expOut(EN);
    reqCmd <= 1'b0;
    $display("test function test done");
    finish_test();
  end
endmodule
